// file: design/gdic_pkg.sv
// Constants, timing helpers and state encoding for the gate driver host controller
// Function
// [R1] Driver drops input pulses under 40 ns
// [R2] Both PWM inputs high force gate low
// [R3] Route complementary PWM to inverting input
// [R4] Never float inputs; unused inverting input low
// [R5] Reset/enable low keeps driver outputs disabled
// [R6] Long low reset/enable soft-disables driver sink
// [R7] Overcurrent latches fault flag and gate low
// [R8] Driver ignores reset during fault mute interval
// [R9] Hold reset low filter time after mute
// [R10] Fault clears on reset/enable rising edge
// [R11] Auto reset: PWM off-time exceeds filter time
// [R12] Fault and power-good are open-drain outputs
package gdic_pkg;

	localparam int CLK_MHZ = 250;
	localparam int DEGLITCH_NS = 40;
	// Mute and filter figures are not fixed here; plain defaults, override at the top
	localparam int FAULT_MUTE_NS_DEF = 1000;
	localparam int CLEAR_FILTER_NS_DEF = 1000;
	localparam int RELEASE_WAIT_NS = 2000;
	// Extra cycles cover the pin synchroniser lag and edge uncertainty
	localparam int MARGIN_CYC = 4;
	localparam int CNT_W_DEF = 16;
	localparam int SYNC_STAGES = 3;

	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_RUN = 5'h02,
		ST_FAULT = 5'h04,
		ST_CLEAR = 5'h08,
		ST_RELEASE = 5'h10
	} gdic_state_t;

	// Least time: rounds up, never below one cycle
	function automatic int ns_to_cyc_ceil(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	// Longest time: rounds down, never below one cycle
	function automatic int ns_to_cyc_floor(input int ns);
		int c;
		c = (ns * CLK_MHZ) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

endpackage

// file: design/gdic_sync.sv
// Three-stage pin synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module gdic_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] level_next;
	integer i;

	always_comb begin
		level_next = level_out;
		for (i = 0; i < W; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				level_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			level_out <= RST_VAL;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_out <= level_next;
		end
	end

endmodule
`default_nettype wire

// file: design/gdic_host.sv
// Host controller driving the isolated gate driver PWM and reset/enable pins and reading its fault and power-good pins
`timescale 1ns/1ps
`default_nettype none
module gdic_host #(
	parameter int FAULT_MUTE_NS = gdic_pkg::FAULT_MUTE_NS_DEF,
	parameter int CLEAR_FILTER_NS = gdic_pkg::CLEAR_FILTER_NS_DEF,
	parameter int CNT_W = gdic_pkg::CNT_W_DEF
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic enable_in,
	input wire logic pwm_this_in,
	input wire logic pwm_comp_in,
	input wire logic use_interlock_in,
	input wire logic auto_reset_in,
	input wire logic auto_clear_in,
	input wire logic clear_req_in,
	input wire logic fault_indicator_n_in,
	input wire logic power_good_in,
	output logic pwm_noninv_out,
	output logic pwm_inv_out,
	output logic rst_en_out,
	output logic fault_out,
	output logic fault_event_out,
	output logic clear_busy_out,
	output logic clear_timeout_out,
	output logic ready_out
);

	localparam int MUTE_CYC = gdic_pkg::ns_to_cyc_ceil(FAULT_MUTE_NS);
	localparam int FILT_CYC = gdic_pkg::ns_to_cyc_ceil(CLEAR_FILTER_NS);
	localparam int DEGL_CYC = gdic_pkg::ns_to_cyc_ceil(gdic_pkg::DEGLITCH_NS);
	localparam int HOLD_CYC = MUTE_CYC + FILT_CYC + gdic_pkg::MARGIN_CYC;
	localparam int REL_CYC = gdic_pkg::ns_to_cyc_floor(gdic_pkg::RELEASE_WAIT_NS);
	localparam int MIN_PW_CYC = DEGL_CYC + gdic_pkg::MARGIN_CYC;
	localparam int MIN_OFF_AUTO_CYC = FILT_CYC + gdic_pkg::MARGIN_CYC;
	localparam logic [CNT_W-1:0] CNT_MAX = '1;
	localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] REL_LOAD = CNT_W'(REL_CYC - 1);
	localparam logic [CNT_W-1:0] MIN_PW_M1 = CNT_W'(MIN_PW_CYC - 1);
	localparam logic [CNT_W-1:0] MIN_OFF_AUTO_M1 = CNT_W'(MIN_OFF_AUTO_CYC - 1);
	localparam logic [1:0] SYNC_RST = 2'h1;

	generate
		if (HOLD_CYC >= (1 << CNT_W) || REL_CYC >= (1 << CNT_W) || CNT_W > 30) begin : g_chk
			$error("gdic_host: CNT_W too narrow for the configured timing");
		end
	endgenerate

	// Local names for the package's state codes; nothing is imported
	localparam gdic_pkg::gdic_state_t ST_OFF = gdic_pkg::ST_OFF;
	localparam gdic_pkg::gdic_state_t ST_RUN = gdic_pkg::ST_RUN;
	localparam gdic_pkg::gdic_state_t ST_FAULT = gdic_pkg::ST_FAULT;
	localparam gdic_pkg::gdic_state_t ST_CLEAR = gdic_pkg::ST_CLEAR;
	localparam gdic_pkg::gdic_state_t ST_RELEASE = gdic_pkg::ST_RELEASE;

	gdic_pkg::gdic_state_t state_reg, state_next;
	logic [CNT_W-1:0] tmr_reg, tmr_next;
	logic [CNT_W-1:0] pw_cnt_reg, pw_cnt_next;
	logic [CNT_W-1:0] low_cnt_reg, low_cnt_next;
	logic noninv_next, inv_next, rst_en_next;
	logic fault_next, event_next, busy_next, timeout_next;
	logic [1:0] pins_sync;
	logic fault_seen;
	logic min_off_met;
	logic min_on_met;

	// Open-drain pins arrive pulled up when released; fault seen while low
	gdic_sync #(.W(2), .RST_VAL(SYNC_RST)) u_sync (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.pin_in({power_good_in, fault_indicator_n_in}),
		.level_out(pins_sync)
	); // [R12]

	assign fault_seen = ~pins_sync[0];
	// Short pulses would be eaten by the driver filter, so each non-inverting level is stretched while in run
	assign min_on_met = (pw_cnt_reg >= MIN_PW_M1); // [R1]
	assign min_off_met = auto_reset_in ? (pw_cnt_reg >= MIN_OFF_AUTO_M1) : min_on_met; // [R11]

	always_comb begin
		state_next = state_reg;
		tmr_next = tmr_reg;
		fault_next = fault_out;
		event_next = 1'b0;
		timeout_next = 1'b0;
		case (state_reg)
			ST_OFF: begin
				if (fault_seen) begin
					state_next = ST_FAULT;
					fault_next = 1'b1;
					event_next = 1'b1;
				end else if (enable_in) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (fault_seen) begin
					state_next = ST_FAULT; // [R7]
					fault_next = 1'b1;
					event_next = 1'b1;
				end else if (!enable_in) begin
					state_next = ST_OFF; // [R5]
				end
			end
			ST_FAULT: begin
				if (clear_req_in || auto_clear_in) begin
					state_next = ST_CLEAR;
					tmr_next = HOLD_LOAD;
				end
			end
			ST_CLEAR: begin
				// Low through mute plus filter; earlier edges would be ignored by the driver
				if (tmr_reg == '0) begin
					state_next = ST_RELEASE; // [R8] [R9]
					tmr_next = REL_LOAD;
				end else begin
					tmr_next = tmr_reg - 1'b1;
				end
			end
			ST_RELEASE: begin
				if (!fault_seen) begin
					state_next = enable_in ? ST_RUN : ST_OFF; // [R10]
					fault_next = 1'b0;
				end else if (tmr_reg == '0) begin
					state_next = ST_FAULT;
					timeout_next = 1'b1;
				end else begin
					tmr_next = tmr_reg - 1'b1;
				end
			end
			default: begin
				state_next = ST_OFF;
				tmr_next = '0;
			end
		endcase
		busy_next = (state_next == ST_CLEAR) || (state_next == ST_RELEASE);
	end

	always_comb begin
		noninv_next = pwm_noninv_out;
		inv_next = 1'b0;
		if (state_next != ST_RUN) begin
			// Leaving run drops the gate command at once; safety beats pulse width here
			noninv_next = 1'b0;
		end else if (pwm_this_in && !pwm_noninv_out && min_off_met) begin
			noninv_next = 1'b1; // [R11]
		end else if (!pwm_this_in && pwm_noninv_out && min_on_met) begin
			noninv_next = 1'b0; // [R1]
		end
		if (state_next == ST_RUN && use_interlock_in) begin
			inv_next = pwm_comp_in; // [R3] [R2]
		end
		// Unused inverting input is held low, never left to float
		if (!use_interlock_in) begin
			inv_next = 1'b0; // [R4]
		end
		case (state_next)
			ST_RUN: rst_en_next = auto_reset_in ? noninv_next : 1'b1; // [R11]
			ST_FAULT: rst_en_next = 1'b1;
			ST_RELEASE: rst_en_next = 1'b1; // [R10]
			ST_CLEAR: rst_en_next = 1'b0; // [R9]
			ST_OFF: rst_en_next = 1'b0; // [R5] [R6]
			default: rst_en_next = 1'b0;
		endcase
		if (noninv_next != pwm_noninv_out) begin
			pw_cnt_next = '0;
		end else begin
			pw_cnt_next = (pw_cnt_reg == CNT_MAX) ? pw_cnt_reg : pw_cnt_reg + 1'b1;
		end
		if (rst_en_next) begin
			low_cnt_next = '0;
		end else begin
			low_cnt_next = (low_cnt_reg == CNT_MAX) ? low_cnt_reg : low_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_reg <= ST_OFF;
			tmr_reg <= '0;
			pw_cnt_reg <= '0;
			low_cnt_reg <= '0;
			pwm_noninv_out <= 1'b0;
			pwm_inv_out <= 1'b0;
			rst_en_out <= 1'b0;
			fault_out <= 1'b0;
			fault_event_out <= 1'b0;
			clear_busy_out <= 1'b0;
			clear_timeout_out <= 1'b0;
			ready_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			pw_cnt_reg <= pw_cnt_next;
			low_cnt_reg <= low_cnt_next;
			pwm_noninv_out <= noninv_next;
			pwm_inv_out <= inv_next;
			rst_en_out <= rst_en_next;
			fault_out <= fault_next;
			fault_event_out <= event_next;
			clear_busy_out <= busy_next;
			clear_timeout_out <= timeout_next;
			ready_out <= pins_sync[1];
		end
	end

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_fault_in_run;
		(state_reg == ST_RUN) && fault_seen;
	endsequence

	sequence s_clear_done;
		(state_reg == ST_CLEAR) && (tmr_reg == '0);
	endsequence

	AST_INV_TIED: assert property (!use_interlock_in |=> !pwm_inv_out) // [R4]
		else $error("inverting input not held low without interlock");

	AST_INV_ROUTE: assert property (
		(state_next == ST_RUN) && use_interlock_in |=> pwm_inv_out == $past(pwm_comp_in)) // [R3]
		else $error("complementary PWM not routed to inverting input");

	AST_FAULT_STOP: assert property (
		s_fault_in_run |=> !pwm_noninv_out && fault_out && fault_event_out ##1 !fault_event_out) // [R7]
		else $error("fault did not stop gate command and flag");

	AST_CLEAR_HOLD: assert property (
		s_clear_done |=> rst_en_out && $past(low_cnt_reg) >= HOLD_LOAD) // [R9]
		else $error("reset released before mute plus filter time");

	AST_CLEAR_LOW: assert property (
		$rose(clear_busy_out) |-> !rst_en_out [*8]) // [R8]
		else $error("reset pin not held low at start of clear");

	AST_AUTO_OFF: assert property (
		auto_reset_in && $rose(pwm_noninv_out) |-> $past(pw_cnt_reg) >= MIN_OFF_AUTO_M1) // [R11]
		else $error("PWM off-time shorter than filter time in auto reset");

	AST_MIN_PULSE: assert property (
		(state_reg == ST_RUN) && (state_next == ST_RUN) && $fell(pwm_noninv_out)
		|-> $past(pw_cnt_reg) >= MIN_PW_M1) // [R1]
		else $error("gate command pulse shorter than deglitch time");

	AST_OFF_DISABLE: assert property (
		(state_reg == ST_RUN) && !enable_in && !fault_seen |=> !rst_en_out && !pwm_noninv_out) // [R5]
		else $error("driver not disabled after enable dropped");

	AST_RELEASE_CLEAR: assert property (
		(state_reg == ST_RELEASE) && !fault_seen |=> !fault_out && !clear_busy_out) // [R10]
		else $error("fault flag not cleared after release");

endmodule
`default_nettype wire

// file: tb/gdic_dev_model.sv
// Behavioural model of the isolated gate driver input side and its status pins
`timescale 1ns/1ps
`default_nettype none
module gdic_dev_model #(
	parameter int MUTE_NS = 40,
	parameter int FILT_NS = 40
) (
	input wire logic in_pos_in,
	input wire logic in_neg_in,
	input wire logic rst_en_in,
	input wire logic oc_trip_in,
	input wire logic supply_ok_in,
	output wire logic fault_indicator_n_out,
	output wire logic power_good_out,
	output wire logic gate_source_out
);
	realtime t_pos = 0, t_neg = 0, t_rst = 0, t_low = 0, t_flt = 0, t_start;
	logic f_pos = 1'b0, f_neg = 1'b0, f_rst = 1'b0, fault = 1'b0;
	always @(in_pos_in) t_pos = $realtime;
	always @(in_neg_in) t_neg = $realtime;
	always @(rst_en_in) t_rst = $realtime;
	always @(posedge oc_trip_in) begin
		fault = 1'b1;
		t_flt = $realtime;
	end
	// Polled every ns: a level must stand 40 ns before it is acted on
	always #1 begin
		if ($realtime - t_pos >= 40) f_pos = in_pos_in;
		if ($realtime - t_neg >= 40) f_neg = in_neg_in;
		if ($realtime - t_rst >= 40 && rst_en_in !== f_rst) begin
			t_start = (t_low > t_flt + MUTE_NS) ? t_low : t_flt + MUTE_NS;
			if (rst_en_in === 1'b0) t_low = $realtime;
			else if (fault && $realtime - t_start >= FILT_NS) fault = 1'b0;
			f_rst = rst_en_in;
		end
	end
	assign gate_source_out = (f_rst & f_pos & ~f_neg & ~fault) === 1'b1;
	assign fault_indicator_n_out = fault ? 1'b0 : 1'bz;
	assign power_good_out = supply_ok_in ? 1'bz : 1'b0;
endmodule
`default_nettype wire

// file: tb/test_gdic_host.sv
// Self-checking testbench of the gate driver host controller against a driver model
`timescale 1ns/1ps
`default_nettype none
module test_gdic_host;
	localparam int HOLD = 24;
	localparam int MIN_PW = 14;
	logic sys_clk_in = 1'b0, rst_in = 1'b1, enable_in = 1'b0, pwm_this_in = 1'b0;
	logic pwm_comp_in = 1'b0, use_interlock_in = 1'b0, auto_reset_in = 1'b0;
	logic auto_clear_in = 1'b0, clear_req_in = 1'b0, oc_trip = 1'b0, supply_ok = 1'b0;
	logic pwm_noninv_out, pwm_inv_out, rst_en_out, fault_out, fault_event_out;
	logic clear_busy_out, clear_timeout_out, ready_out, gate;
	tri1 fault_n_w, pg_w;
	int bad_count = 0, check_count = 0, n;
	always #2 sys_clk_in = ~sys_clk_in;
	gdic_host #(.FAULT_MUTE_NS(40), .CLEAR_FILTER_NS(40)) i_gdic_host (.sys_clk_in, .rst_in,
		.enable_in, .pwm_this_in, .pwm_comp_in, .use_interlock_in, .auto_reset_in,
		.auto_clear_in, .clear_req_in, .fault_indicator_n_in(fault_n_w), .power_good_in(pg_w),
		.pwm_noninv_out, .pwm_inv_out, .rst_en_out, .fault_out, .fault_event_out,
		.clear_busy_out, .clear_timeout_out, .ready_out);
	gdic_dev_model #(.MUTE_NS(40), .FILT_NS(40)) i_gdic_dev_model (.in_pos_in(pwm_noninv_out),
		.in_neg_in(pwm_inv_out), .rst_en_in(rst_en_out), .oc_trip_in(oc_trip),
		.supply_ok_in(supply_ok), .fault_indicator_n_out(fault_n_w), .power_good_out(pg_w),
		.gate_source_out(gate));
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic check(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic final_report;
		if (bad_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Bounded wait on the latched fault flag; running out ends the run
	task automatic wait_fault(input logic lvl, input int lim);
		int i;
		for (i = 0; i < lim && fault_out !== lvl; i++) cyc(1);
		if (i == lim) begin
			bad_count++;
			$display("wrong value fault_out wait expected %b seen %b", lvl, fault_out);
			final_report();
		end
	endtask
	task automatic t_ready;
		check("ready_out", 1'b0, ready_out);
		supply_ok = 1'b1;
		cyc(8);
		check("ready_out", 1'b1, ready_out);
	endtask
	task automatic t_run;
		enable_in = 1'b1;
		pwm_this_in = 1'b1;
		use_interlock_in = 1'b1;
		cyc(20);
		check("rst_en_out", 1'b1, rst_en_out);
		check("gate", 1'b1, gate);
		clear_req_in = 1'b1;
		cyc(1);
		clear_req_in = 1'b0;
		cyc(2);
		check("rst_en_out", 1'b1, rst_en_out);
		pwm_comp_in = 1'b1;
		cyc(20);
		check("pwm_inv_out", 1'b1, pwm_inv_out);
		check("gate", 1'b0, gate);
		use_interlock_in = 1'b0;
		cyc(20);
		check("pwm_inv_out", 1'b0, pwm_inv_out);
		check("gate", 1'b1, gate);
		pwm_comp_in = 1'b0;
	endtask
	task automatic t_pulse;
		pwm_this_in = 1'b0;
		cyc(20);
		pwm_this_in = 1'b1;
		cyc(1);
		pwm_this_in = 1'b0;
		n = 0;
		repeat (40) begin
			n += pwm_noninv_out;
			cyc(1);
		end
		check("noninv_width", 1'b1, n == MIN_PW);
		check("gate", 1'b0, gate);
	endtask
	task automatic t_fault;
		pwm_this_in = 1'b1;
		cyc(20);
		oc_trip = 1'b1;
		wait_fault(1'b1, 20);
		check("fault_event_out", 1'b1, fault_event_out);
		cyc(1);
		oc_trip = 1'b0;
		check("fault_event_out", 1'b0, fault_event_out);
		check("pwm_noninv_out", 1'b0, pwm_noninv_out);
		cyc(20);
		check("gate", 1'b0, gate);
		check("fault_out", 1'b1, fault_out);
		clear_req_in = 1'b1;
		cyc(1);
		clear_req_in = 1'b0;
		check("clear_busy_out", 1'b1, clear_busy_out);
		for (n = 0; n < 600 && rst_en_out !== 1'b1; n++) cyc(1);
		check("reset_low_len", 1'b1, n == HOLD);
		wait_fault(1'b0, 100);
		check("fault_pin", 1'b1, fault_n_w);
		check("clear_busy_out", 1'b0, clear_busy_out);
		check("clear_timeout_out", 1'b0, clear_timeout_out);
	endtask
	task automatic t_auto;
		auto_reset_in = 1'b1;
		auto_clear_in = 1'b1;
		pwm_this_in = 1'b0;
		cyc(30);
		check("rst_en_out", 1'b0, rst_en_out);
		pwm_this_in = 1'b1;
		cyc(20);
		check("rst_en_out", 1'b1, rst_en_out);
		oc_trip = 1'b1;
		wait_fault(1'b1, 20);
		oc_trip = 1'b0;
		wait_fault(1'b0, 700);
		auto_reset_in = 1'b0;
		enable_in = 1'b0;
		cyc(3);
		check("rst_en_out", 1'b0, rst_en_out);
		cyc(20);
		check("gate", 1'b0, gate);
	endtask
	initial begin
		cyc(10);
		rst_in = 1'b0;
		t_ready();
		t_run();
		t_pulse();
		t_fault();
		t_auto();
		final_report();
	end
endmodule
`default_nettype wire
